/* File: pcs_map.svh */
// Register map, field positions, reset values and interrupt bits for the power control status block
// Notes on behaviour
// - Sequence status bits 18:16 show the sequencer's present state, codes 0 to 7.
// - Sequence status shows which supplies were enabled in the previous sequencer state.
// - Sequence status mirrors tile clock disable, both modulation selects, four supply enables.
// - Power-good threshold 2 bits: 0.80, 0.85, 0.90, 0.75; resets to 2.
// - Writing 1 to error-clear clears both converters' error flags; software writes 0 back.
// - Analogue converter current limit: 1A, 1.5A, 2A, 0.5A; resets to 0.
// - Analogue converter clock: 0.9, 1.0, 1.1, 1.2 MHz; resets to code 1.
// - Core converter current limit: 1.2A, 1.8A, 2.5A, 0.8A; resets to 0.
// - Core converter clock: 0.9, 1.0, 1.1, 1.2 MHz; resets to code 1.
// - Supply status shows oscillator stable, PLL supply good, core supply good.
// - Supply status shows per converter a current-limiting flag.
// - Supply status shows per converter a soft-start flag.
// - Core rail level is 7 bits, 10 mV steps, code 0 is 0.60V.
// - Core rail and PLL regulator level reset values come from the mode pins.
// - PLL regulator level is 3 bits, 100 mV steps, code 0 is 0.6V.
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

`define PCS_OFF_SEQ_STATUS   8'h24
`define PCS_OFF_CONV_CTRL    8'h2c
`define PCS_OFF_SUPPLY_STAT  8'h30
`define PCS_OFF_CORE_LEVEL   8'h34
`define PCS_OFF_PLL_LEVEL    8'h40
`define PCS_OFF_IRQ_STATUS   8'h50
`define PCS_OFF_IRQ_MASK     8'h54

// Sequence status fields
`define PCS_SEQ_PREV_IO      29
`define PCS_SEQ_PREV_PLL     28
`define PCS_SEQ_PREV_ANA     25
`define PCS_SEQ_PREV_CORE    24
`define PCS_SEQ_STATE_LSB    16
`define PCS_SEQ_TILE_CLK_OFF 14
`define PCS_SEQ_ANA_PFM      9
`define PCS_SEQ_CORE_PFM     8
`define PCS_SEQ_IO_EN        5
`define PCS_SEQ_PLL_EN       4
`define PCS_SEQ_ANA_EN       1
`define PCS_SEQ_CORE_EN      0

// Converter control fields
`define PCS_CC_PGOOD_LSB     24
`define PCS_CC_ERR_CLR       16
`define PCS_CC_ANA_ILIM_LSB  13
`define PCS_CC_ANA_CLK_LSB   8
`define PCS_CC_CORE_ILIM_LSB 5
`define PCS_CC_CORE_CLK_LSB  0
`define PCS_CC_PGOOD_RST     2'h2
`define PCS_CC_ANA_ILIM_RST  2'h0
`define PCS_CC_ANA_CLK_RST   2'h1
`define PCS_CC_CORE_ILIM_RST 2'h0
`define PCS_CC_CORE_CLK_RST  2'h1

// Supply status fields
`define PCS_SS_OSC_OK        24
`define PCS_SS_PLL_GOOD      19
`define PCS_SS_CORE_GOOD     16
`define PCS_SS_ANA_ILIM      9
`define PCS_SS_CORE_ILIM     8
`define PCS_SS_ANA_SOFT      1
`define PCS_SS_CORE_SOFT     0

// Interrupt status and mask bits
`define PCS_IRQ_CORE_GOOD_LOST 0
`define PCS_IRQ_PLL_GOOD_LOST  1
`define PCS_IRQ_CORE_ILIM      2
`define PCS_IRQ_ANA_ILIM       3
`define PCS_IRQ_STATE_CHANGE   4
`define PCS_IRQ_WIDTH          5

`endif

/* File: pcs_pkg.sv */
// Types shared by the power control status block
package pcs_pkg;

  typedef enum logic [2:0] {
    PCS_ST_RESET      = 3'b000,
    PCS_ST_ASLEEP     = 3'b001,
    PCS_ST_WAKING1    = 3'b010,
    PCS_ST_WAKING2    = 3'b011,
    PCS_ST_AWAKE_WAIT = 3'b100,
    PCS_ST_AWAKE      = 3'b101,
    PCS_ST_SLEEPING1  = 3'b110,
    PCS_ST_SLEEPING2  = 3'b111
  } pcs_seq_state_t;

  // Live supply configuration driven by the sequencer
  typedef struct packed {
    logic tile_clk_off;
    logic ana_pfm;
    logic core_pfm;
    logic io_supply_output_en;
    logic pll_linear_regulator_en;
    logic analog_buck_converter_en;
    logic core_buck_converter_en;
  } pcs_supply_cfg_t;

  // Enables seen in the previous sequencer state
  typedef struct packed {
    logic io_en;
    logic pll_en;
    logic ana_en;
    logic core_en;
  } pcs_prev_en_t;

  // Indications from the analogue side
  typedef struct packed {
    logic osc_stable;
    logic pll_supply_rail_good;
    logic core_supply_rail_good;
    logic ana_ilim;
    logic core_ilim;
    logic ana_soft_start;
    logic core_soft_start;
  } pcs_analog_stat_t;

  // Settings sent to the converters and regulators
  typedef struct packed {
    logic [1:0] pgood_sel;
    logic       err_clear;
    logic [1:0] ana_ilim_sel;
    logic [1:0] ana_clk_sel;
    logic [1:0] core_ilim_sel;
    logic [1:0] core_clk_sel;
    logic [6:0] core_level;
    logic [2:0] pll_level;
  } pcs_conv_settings_t;

endpackage

/* File: pcs_regs.sv */
// APB register block reporting and steering the on-chip power supplies
//
// Chosen here: the APB slave port.
`include "pcs_map.svh"

module pcs_regs
  import pcs_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // Sequencer, same clock
  input  wire pcs_seq_state_t     seq_state,
  input  wire pcs_prev_en_t       prev_en,
  input  wire pcs_supply_cfg_t    supply_cfg,
  // Analogue indications, asynchronous
  input  wire pcs_analog_stat_t   analog_stat,
  // Mode pins giving level reset values
  input  wire logic [6:0]         mode_core_level,
  input  wire logic [2:0]         mode_pll_level,
  // Converter settings
  output pcs_conv_settings_t      conv_settings,
  // Interrupt
  output logic                    irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic        setup;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;

  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = setup & ~pwrite;
  assign pready  = 1'b1;

  always_comb begin
    case (paddr)
      `PCS_OFF_SEQ_STATUS,
      `PCS_OFF_CONV_CTRL,
      `PCS_OFF_SUPPLY_STAT,
      `PCS_OFF_CORE_LEVEL,
      `PCS_OFF_PLL_LEVEL,
      `PCS_OFF_IRQ_STATUS,
      `PCS_OFF_IRQ_MASK:  addr_ok = (paddr[1:0] == 2'b00);
      default:            addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronise analogue indications: three flops, count on agreement

  pcs_analog_stat_t sync1;
  pcs_analog_stat_t sync2;
  pcs_analog_stat_t sync3;
  pcs_analog_stat_t stat;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= analog_stat;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Filtered value only moves where stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= '0;
    end else begin
      stat <= (stat & (sync2 | sync3)) | (sync2 & sync3);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter control register

  logic [1:0] pgood_sel;
  logic       err_clear;
  logic [1:0] ana_ilim_sel;
  logic [1:0] ana_clk_sel;
  logic [1:0] core_ilim_sel;
  logic [1:0] core_clk_sel;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pgood_sel     <= `PCS_CC_PGOOD_RST;
      err_clear     <= 1'b0;
      ana_ilim_sel  <= `PCS_CC_ANA_ILIM_RST;
      ana_clk_sel   <= `PCS_CC_ANA_CLK_RST;
      core_ilim_sel <= `PCS_CC_CORE_ILIM_RST;
      core_clk_sel  <= `PCS_CC_CORE_CLK_RST;
    end else if (wr_en && paddr == `PCS_OFF_CONV_CTRL) begin
      if (pstrb[3]) begin
        pgood_sel <= pwdata[`PCS_CC_PGOOD_LSB +: 2];
      end
      if (pstrb[2]) begin
        err_clear <= pwdata[`PCS_CC_ERR_CLR];
      end
      if (pstrb[1]) begin
        ana_ilim_sel <= pwdata[`PCS_CC_ANA_ILIM_LSB +: 2];
        ana_clk_sel  <= pwdata[`PCS_CC_ANA_CLK_LSB +: 2];
      end
      if (pstrb[0]) begin
        core_ilim_sel <= pwdata[`PCS_CC_CORE_ILIM_LSB +: 2];
        core_clk_sel  <= pwdata[`PCS_CC_CORE_CLK_LSB +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level registers; reset value caught from mode pins after release

  logic [6:0] core_level;
  logic [2:0] pll_level;
  logic       strap_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done <= 1'b0;
    end else begin
      strap_done <= 1'b1;
    end
  end

  // Slew limits are software's job; the register takes any code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_level <= 7'h00;
      pll_level  <= 3'h0;
    end else if (!strap_done) begin
      core_level <= mode_core_level;
      pll_level  <= mode_pll_level;
    end else if (wr_en && pstrb[0]) begin
      if (paddr == `PCS_OFF_CORE_LEVEL) begin
        core_level <= pwdata[6:0];
      end
      if (paddr == `PCS_OFF_PLL_LEVEL) begin
        pll_level <= pwdata[2:0];
      end
    end
  end

  assign conv_settings = '{pgood_sel:     pgood_sel,
                           err_clear:     err_clear,
                           ana_ilim_sel:  ana_ilim_sel,
                           ana_clk_sel:   ana_clk_sel,
                           core_ilim_sel: core_ilim_sel,
                           core_clk_sel:  core_clk_sel,
                           core_level:    core_level,
                           pll_level:     pll_level};

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events

  logic [`PCS_IRQ_WIDTH-1:0] irq_status;
  logic [`PCS_IRQ_WIDTH-1:0] irq_mask;
  logic [`PCS_IRQ_WIDTH-1:0] event_now;
  pcs_analog_stat_t          stat_q;
  pcs_seq_state_t            state_q;
  logic                      armed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q  <= '0;
      state_q <= PCS_ST_RESET;
      armed   <= 1'b0;
    end else begin
      stat_q  <= stat;
      state_q <= seq_state;
      armed   <= strap_done;
    end
  end

  always_comb begin
    event_now = '0;
    event_now[`PCS_IRQ_CORE_GOOD_LOST] = stat_q.core_supply_rail_good & ~stat.core_supply_rail_good;
    event_now[`PCS_IRQ_PLL_GOOD_LOST]  = stat_q.pll_supply_rail_good & ~stat.pll_supply_rail_good;
    event_now[`PCS_IRQ_CORE_ILIM]      = ~stat_q.core_ilim & stat.core_ilim;
    event_now[`PCS_IRQ_ANA_ILIM]       = ~stat_q.ana_ilim & stat.ana_ilim;
    event_now[`PCS_IRQ_STATE_CHANGE]   = armed & (state_q != seq_state);
  end

  // A new event wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else if (wr_en && pstrb[0] && paddr == `PCS_OFF_IRQ_STATUS) begin
      irq_status <= (irq_status & ~pwdata[`PCS_IRQ_WIDTH-1:0]) | event_now;
    end else begin
      irq_status <= irq_status | event_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= '0;
    end else if (wr_en && pstrb[0] && paddr == `PCS_OFF_IRQ_MASK) begin
      irq_mask <= pwdata[`PCS_IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; unlisted bits stay zero

  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      `PCS_OFF_SEQ_STATUS: begin
        rd_word[`PCS_SEQ_PREV_IO]              = prev_en.io_en;
        rd_word[`PCS_SEQ_PREV_PLL]             = prev_en.pll_en;
        rd_word[`PCS_SEQ_PREV_ANA]             = prev_en.ana_en;
        rd_word[`PCS_SEQ_PREV_CORE]            = prev_en.core_en;
        rd_word[`PCS_SEQ_STATE_LSB +: 3]       = seq_state;
        rd_word[`PCS_SEQ_TILE_CLK_OFF]         = supply_cfg.tile_clk_off;
        rd_word[`PCS_SEQ_ANA_PFM]              = supply_cfg.ana_pfm;
        rd_word[`PCS_SEQ_CORE_PFM]             = supply_cfg.core_pfm;
        rd_word[`PCS_SEQ_IO_EN]                = supply_cfg.io_supply_output_en;
        rd_word[`PCS_SEQ_PLL_EN]               = supply_cfg.pll_linear_regulator_en;
        rd_word[`PCS_SEQ_ANA_EN]               = supply_cfg.analog_buck_converter_en;
        rd_word[`PCS_SEQ_CORE_EN]              = supply_cfg.core_buck_converter_en;
      end
      `PCS_OFF_CONV_CTRL: begin
        rd_word[`PCS_CC_PGOOD_LSB +: 2]        = pgood_sel;
        rd_word[`PCS_CC_ERR_CLR]               = err_clear;
        rd_word[`PCS_CC_ANA_ILIM_LSB +: 2]     = ana_ilim_sel;
        rd_word[`PCS_CC_ANA_CLK_LSB +: 2]      = ana_clk_sel;
        rd_word[`PCS_CC_CORE_ILIM_LSB +: 2]    = core_ilim_sel;
        rd_word[`PCS_CC_CORE_CLK_LSB +: 2]     = core_clk_sel;
      end
      `PCS_OFF_SUPPLY_STAT: begin
        rd_word[`PCS_SS_OSC_OK]                = stat.osc_stable;
        rd_word[`PCS_SS_PLL_GOOD]              = stat.pll_supply_rail_good;
        rd_word[`PCS_SS_CORE_GOOD]             = stat.core_supply_rail_good;
        rd_word[`PCS_SS_ANA_ILIM]              = stat.ana_ilim;
        rd_word[`PCS_SS_CORE_ILIM]             = stat.core_ilim;
        rd_word[`PCS_SS_ANA_SOFT]              = stat.ana_soft_start;
        rd_word[`PCS_SS_CORE_SOFT]             = stat.core_soft_start;
      end
      `PCS_OFF_CORE_LEVEL:  rd_word[6:0]       = core_level;
      `PCS_OFF_PLL_LEVEL:   rd_word[2:0]       = pll_level;
      `PCS_OFF_IRQ_STATUS:  rd_word[`PCS_IRQ_WIDTH-1:0] = irq_status;
      `PCS_OFF_IRQ_MASK:    rd_word[`PCS_IRQ_WIDTH-1:0] = irq_mask;
      default:              rd_word = 32'h0000_0000;
    endcase
  end

  // Data captured at setup so it stands through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= addr_ok ? rd_word : 32'h0000_0000;
    end
  end

endmodule

/* File: pcs_regs_sva.sv */
// Checker of the power control status register block
module pcs_regs_sva
  import pcs_pkg::*;
(
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // APB
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic               pready,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  // Sequencer and analogue side
  input wire pcs_seq_state_t     seq_state,
  input wire pcs_prev_en_t       prev_en,
  input wire pcs_supply_cfg_t    supply_cfg,
  input wire pcs_analog_stat_t   analog_stat,
  input wire logic [6:0]         mode_core_level,
  input wire logic [2:0]         mode_pll_level,
  input wire pcs_conv_settings_t conv_settings,
  input wire logic               irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic        rd_acc;
  logic        wr_acc;
  logic [31:0] exp_seq;
  logic [31:0] exp_cc;
  assign rd_acc = psel && penable && !pwrite;
  assign wr_acc = psel && penable && pwrite;
  // Words as they stood at the setup edge
  always_ff @(posedge pclk) begin
    exp_seq <= {2'h0, prev_en[3:2], 2'h0, prev_en[1:0], 5'h00, seq_state, 1'h0, supply_cfg[6], 4'h0,
                supply_cfg[5:4], 2'h0, supply_cfg[3:2], 2'h0, supply_cfg[1:0]};
  end
  always_ff @(posedge pclk) begin
    exp_cc <= {6'h00, conv_settings.pgood_sel, 7'h00, conv_settings.err_clear, 1'h0, conv_settings.ana_ilim_sel,
               3'h0, conv_settings.ana_clk_sel, 1'h0, conv_settings.core_ilim_sel, 3'h0, conv_settings.core_clk_sel};
  end
  AST_SEQ_RD: assert property (rd_acc && paddr == 8'h24 |-> prdata == exp_seq)
    else $error("sequence status read mismatch");
  AST_CC_RD: assert property (rd_acc && paddr == 8'h2c |-> prdata == exp_cc)
    else $error("converter control read mismatch");
  AST_CORE_RD: assert property (rd_acc && paddr == 8'h34 |-> prdata == {25'h0, $past(conv_settings.core_level)})
    else $error("core level read mismatch");
  AST_PLL_RD: assert property (rd_acc && paddr == 8'h40 |-> prdata == {29'h0, $past(conv_settings.pll_level)})
    else $error("pll level read mismatch");
  AST_WR_CORE: assert property (wr_acc && paddr == 8'h34 && pstrb[0] |=> conv_settings.core_level == $past(pwdata[6:0]))
    else $error("core level write not applied");
  AST_WR_PLL: assert property (wr_acc && paddr == 8'h40 && pstrb[0] |=> conv_settings.pll_level == $past(pwdata[2:0]))
    else $error("pll level write not applied");
  AST_RO_WR: assert property (wr_acc && (paddr == 8'h24 || paddr == 8'h30) |=> $stable(conv_settings))
    else $error("write to read-only register had an effect");
  AST_SLVERR: assert property (psel && penable && paddr == 8'h44 |-> pslverr && pready)
    else $error("unmapped access not flagged");
  AST_RST_LEVEL: assert property ($rose(presetn) |=> conv_settings.core_level == $past(mode_core_level) &&
                                  conv_settings.pll_level == $past(mode_pll_level))
    else $error("level fields not loaded from mode pins");
  AST_OK_ACC: assert property (psel && penable && paddr == 8'h2c |-> pready && !pslverr)
    else $error("mapped access refused");
endmodule

bind pcs_regs pcs_regs_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .seq_state(seq_state), .prev_en(prev_en), .supply_cfg(supply_cfg),
  .analog_stat(analog_stat), .mode_core_level(mode_core_level), .mode_pll_level(mode_pll_level),
  .conv_settings(conv_settings), .irq(irq));

/* File: pcs_supply_model.sv */
// Behavioural analogue supplies with latched current-limit errors
module pcs_supply_model
  import pcs_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Bench command and settings
  input  wire pcs_analog_stat_t   cmd,
  input  wire pcs_conv_settings_t conv_settings,
  // Indications
  output pcs_analog_stat_t        analog_stat
);
  timeunit 1ns;
  timeprecision 1ps;
  pcs_analog_stat_t live;
  logic             ana_err;
  logic             core_err;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) live <= '0;
    else live <= cmd;
  end
  // Error stays until cleared, and clear holds while the bit is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ana_err  <= 1'h0;
      core_err <= 1'h0;
    end else if (conv_settings.err_clear) begin
      ana_err  <= 1'h0;
      core_err <= 1'h0;
    end else begin
      ana_err  <= ana_err | cmd.ana_ilim;
      core_err <= core_err | cmd.core_ilim;
    end
  end
  assign analog_stat = {live[6:4], ana_err, core_err, live[1:0]};
endmodule

/* File: pcs_regs_bench.sv */
// Register-level testbench of the power control status block
module pcs_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, q;
  logic [3:0]         pstrb;
  logic [6:0]         mode_core_level;
  logic [2:0]         mode_pll_level;
  logic               e;
  pcs_seq_state_t     seq_state;
  pcs_prev_en_t       prev_en;
  pcs_supply_cfg_t    supply_cfg;
  pcs_analog_stat_t   analog_stat, cmd;
  pcs_conv_settings_t conv_settings;
  logic [31:0]        d;
  int                 n_fail, checks;

  pcs_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .seq_state(seq_state), .prev_en(prev_en), .supply_cfg(supply_cfg), .analog_stat(analog_stat),
    .mode_core_level(mode_core_level), .mode_pll_level(mode_pll_level), .conv_settings(conv_settings), .irq(irq));
  pcs_supply_model supply (.pclk(pclk), .presetn(presetn), .cmd(cmd), .conv_settings(conv_settings),
    .analog_stat(analog_stat));

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      n_fail++;
      complete_run();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0000_0000, 4'h0);
    chk(q, exp);
  endtask
  function automatic logic [31:0] seq_word(input logic [2:0] st, input logic [3:0] pe, input logic [6:0] sc);
    return {2'h0, pe[3:2], 2'h0, pe[1:0], 5'h00, st, 1'h0, sc[6], 4'h0, sc[5:4], 2'h0, sc[3:2], 2'h0, sc[1:0]};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    seq_state = PCS_ST_RESET;
    {prev_en, supply_cfg, cmd, n_fail, checks} = '0;
    mode_core_level = 7'h2a;
    mode_pll_level = 3'h3;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    rd(8'h34, 32'h0000_002a);
    rd(8'h40, 32'h0000_0003);
    rd(8'h2c, 32'h0200_0101);
    for (int c = 0; c < 4; c++) begin
      d = c * 32'h5555_5555;
      apb(1'h1, 8'h2c, d, 4'hf);
      rd(8'h2c, d & 32'h0301_6363);
      chk({22'h0, conv_settings.pgood_sel, conv_settings.ana_ilim_sel, conv_settings.ana_clk_sel,
           conv_settings.core_ilim_sel, conv_settings.core_clk_sel},
          {22'h0, d[25:24], d[14:13], d[9:8], d[6:5], d[1:0]});
    end
    // Lane 0 alone must touch only the core converter fields
    apb(1'h1, 8'h2c, 32'h0000_0000, 4'h1);
    rd(8'h2c, 32'h0301_6300);
    apb(1'h1, 8'h2c, 32'h0200_0101, 4'hf);
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      seq_state <= pcs_seq_state_t'(3'(i));
      prev_en <= pcs_prev_en_t'(~4'(i));
      supply_cfg <= pcs_supply_cfg_t'(7'(i * 19));
      rd(8'h24, seq_word(3'(i), ~4'(i), 7'(i * 19)));
    end
    apb(1'h1, 8'h24, 32'hffff_ffff, 4'hf);
    apb(1'h1, 8'h30, 32'hffff_ffff, 4'hf);
    rd(8'h24, seq_word(3'h7, 4'h8, 7'h05));
    rd(8'h2c, 32'h0200_0101);
    rd(8'h44, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    apb(1'h1, 8'h48, 32'hffff_ffff, 4'hf);
    chk(32'(e), 32'h0000_0001);
    // Supply indications, then error clear held and written back
    cmd <= 7'h7f;
    repeat (8) @(posedge pclk);
    rd(8'h30, 32'h0109_0303);
    cmd <= 7'h73;
    apb(1'h1, 8'h2c, 32'h0201_0101, 4'hf);
    repeat (8) @(posedge pclk);
    rd(8'h30, 32'h0109_0003);
    chk(32'(conv_settings.err_clear), 32'h0000_0001);
    apb(1'h1, 8'h2c, 32'h0200_0101, 4'hf);
    // The write lands at the edge the task returns on; look one edge later
    @(posedge pclk);
    chk(32'(conv_settings.err_clear), 32'h0000_0000);
    cmd <= 7'h00;
    repeat (8) @(posedge pclk);
    rd(8'h30, 32'h0000_0000);
    rd(8'h50, 32'h0000_001f);
    chk(32'(irq), 32'h0000_0000);
    apb(1'h1, 8'h54, 32'h0000_0010, 4'hf);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0000_0001);
    apb(1'h1, 8'h54, 32'h0000_0000, 4'hf);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0000_0000);
    apb(1'h1, 8'h54, 32'h0000_001f, 4'hf);
    apb(1'h1, 8'h50, 32'h0000_000f, 4'hf);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0000_0001);
    rd(8'h50, 32'h0000_0010);
    apb(1'h1, 8'h50, 32'h0000_0010, 4'hf);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0000_0000);
    // One 10 mV step per microsecond
    apb(1'h1, 8'h34, 32'h0000_002b, 4'hf);
    repeat (100) @(posedge pclk);
    apb(1'h1, 8'h34, 32'hffff_ffac, 4'hf);
    rd(8'h34, 32'h0000_002c);
    apb(1'h1, 8'h40, 32'hffff_fffc, 4'hf);
    apb(1'h1, 8'h40, 32'h0000_0005, 4'he);
    rd(8'h40, 32'h0000_0004);
    chk({22'h0, conv_settings.core_level, conv_settings.pll_level}, 32'h0000_0164);
    // Reset again in mid-run with other straps
    presetn <= 1'h0;
    mode_core_level <= 7'h10;
    mode_pll_level <= 3'h2;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    rd(8'h34, 32'h0000_0010);
    rd(8'h40, 32'h0000_0002);
    rd(8'h2c, 32'h0200_0101);
    complete_run();
  end
endmodule
